// file: hdl/fbg_pkg.sv
// Constants and types for the fieldbus process image gateway
// Function
// - Virtual output n is carried in bit n mod 8 of output image byte n div 8.
// - Up to 128 virtual inputs and outputs occupy image bytes 0 to 15.
// - Status bits 0 to 4 carry output fault, input fault, fault, diagnostic, run.
// - Status bit 5 shows that data exchange with the controller is active.
// - The master sends table and segment numbers and gets the first 3 of the 15 segment bytes.
// - A switch-set address is 192.168.0.x with mask 255.255.255.0.
// - The last address byte comes from the switches, valid from 1 to 255.
// - The switches read as an unsigned byte, first switch most significant.
// - A store command keeps the supplied IP settings in the module.
// - All switches zero at power-up selects the stored IP settings.
// - The address choice is sampled only once after power-up.
// - Each cyclic exchange carries twenty bytes in each direction.
// - Virtual input n is taken from bit n mod 8 of input byte n div 8.
// - Input area starts at register 0, output area at register 1024.
package fbg_pkg;
	localparam int IMG_BYTES = 20;
	localparam int VIO_BITS = 128;
	localparam int VIO_BYTES = 16;
	localparam int STAT_BYTE = 16;
	localparam int PAY_BYTES = 15;
	localparam int PAY_FIRST = 17;
	localparam int TBL_BYTE = 17;
	localparam int SEG_BYTE = 18;
	localparam int BIT_OUTPUT_FAULT_FLAG = 0;
	localparam int BIT_INPUT_FAULT_FLAG = 1;
	localparam int BIT_FAULT = 2;
	localparam int BIT_DIAGNOSTIC_FLAG = 3;
	localparam int BIT_RUN = 4;
	localparam int BIT_XCHG = 5;
	localparam logic [15:0] IN_REG_BASE = 16'h0000;
	localparam logic [15:0] OUT_REG_BASE = 16'h0400;
	localparam logic [23:0] NET_PREFIX = 24'hC0A800;
	localparam logic [31:0] NET_MASK = 32'hFFFFFF00;
	localparam logic [7:0] SW_ZERO = 8'h00;
	localparam int SEG_ADDR_W = 8;
	typedef enum logic [1:0] {
		FBG_IDLE = 2'b00,
		FBG_SHIFT = 2'b01,
		FBG_DONE = 2'b10
	} fbg_state_t;
endpackage

// file: hdl/fbg_ip_if.sv
// Interface carrying the stored IP settings between gateway modules
`timescale 1ns/100ps
interface fbg_ip_if;
	logic wr_en;
	logic [31:0] wr_addr;
	logic [31:0] wr_mask;
	logic [31:0] rd_addr;
	logic [31:0] rd_mask;
	modport store(input wr_en, wr_addr, wr_mask, output rd_addr, rd_mask);
	modport user(output wr_en, wr_addr, wr_mask, input rd_addr, rd_mask);
endinterface

// file: hdl/fbg_ip_store.sv
// Retained IP settings store
`timescale 1ns/100ps
module fbg_ip_store (
	input wire logic ref_clk_i, // System clock
	input wire logic resetn_i, // Async reset, active low
	fbg_ip_if.store ip // Write and read of stored settings
);
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] mask;
	} fbg_st_t;
	fbg_st_t st_r;
	fbg_st_t st_nxt;

	// Stand-in for the retained cells; reset models an empty store
	always_comb begin
		st_nxt = st_r;
		if (ip.wr_en) begin
			st_nxt.addr = ip.wr_addr;
			st_nxt.mask = ip.wr_mask;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign ip.rd_addr = st_r.addr;
	assign ip.rd_mask = st_r.mask;
endmodule

// file: hdl/fbg_seg_mem.sv
// Payload table memory with registered read
`timescale 1ns/100ps
module fbg_seg_mem #(
	parameter int AW = 8 // Table and segment address width
) (
	input wire logic ref_clk_i, // System clock
	input wire logic wr_en_i, // Write strobe from controller
	input wire logic [AW-1:0] wr_seg_i, // Segment written
	input wire logic [119:0] wr_data_i, // Fifteen bytes of segment
	input wire logic [AW-1:0] rd_seg_i, // Segment polled
	output logic [119:0] rd_data_o // Registered segment data
);
	logic [119:0] mem [0:(1<<AW)-1];

	// Read data always from a register
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i)
			mem[wr_seg_i] <= wr_data_i;
		rd_data_o <= mem[rd_seg_i];
	end
endmodule

// file: hdl/fbg_gateway.sv
// Fieldbus process image builder and IP address selection
`timescale 1ns/100ps
module fbg_gateway #(
	parameter int TBL_W = 4 // Table number bits used for addressing
) (
	input wire logic ref_clk_i, // 100 MHz clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic power_up_i, // Pulse: supply applied
	input wire logic [7:0] dip_sw_i, // Front switches, bit 7 first
	input wire logic xchg_active_i, // Controller exchange running
	input wire logic [127:0] virt_out_i, // Virtual outputs from controller
	input wire logic output_fault_flag_i, // Controller output fault
	input wire logic input_fault_flag_i, // Controller input fault
	input wire logic fault_flag_i, // Controller general fault
	input wire logic diagnostic_flag_i, // Controller diagnostic
	input wire logic run_flag_i, // Controller run
	input wire logic pay_wr_i, // Payload segment write
	input wire logic [7:0] pay_wr_seg_i, // Payload write address
	input wire logic [119:0] pay_wr_data_i, // Payload write data
	input wire logic rx_valid_i, // Byte from master valid
	input wire logic [7:0] rx_data_i, // Byte from master
	input wire logic tx_start_i, // Start a twenty byte answer
	input wire logic store_cfg_i, // Store IP settings pulse
	input wire logic [31:0] cfg_addr_i, // IP address to store
	input wire logic [31:0] cfg_mask_i, // Subnet mask to store
	output logic [127:0] virt_in_o, // Virtual inputs from master
	output logic rx_frame_o, // Pulse: twenty bytes received
	output logic tx_valid_o, // Byte to master valid
	output logic [7:0] tx_data_o, // Byte to master
	output logic [31:0] ip_addr_o, // Active IPv4 address
	output logic [31:0] ip_mask_o, // Active subnet mask
	output logic ip_from_store_o, // Stored settings in use
	output logic [15:0] in_reg_base_o, // Register of input area
	output logic [15:0] out_reg_base_o // Register of output area
);
	typedef struct packed {
		fbg_pkg::fbg_state_t tx_st;
		logic [4:0] tx_cnt;
		logic [4:0] rx_cnt;
		logic [159:0] rx_img;
		logic [159:0] tx_img;
		logic [127:0] vin;
		logic rx_frame;
		logic tx_valid;
		logic [7:0] tx_data;
		logic [7:0] tbl;
		logic [7:0] seg;
		logic ip_sampled;
		logic from_store;
		logic [31:0] ip_addr;
		logic [31:0] ip_mask;
		logic [15:0] in_base;
		logic [15:0] out_base;
	} fbg_gw_t;

	fbg_gw_t s_r;
	fbg_gw_t s_nxt;
	fbg_ip_if ipb ();
	logic [119:0] seg_data;
	logic [7:0] rd_seg;
	// Only the first payload bytes fit behind the status byte
	localparam int PAY_FIT = (fbg_pkg::IMG_BYTES - fbg_pkg::PAY_FIRST) * 8;

	// Byte n of a flat image, byte 0 in the low bits
	function automatic logic [7:0] img_byte(input logic [159:0] img,
		input logic [4:0] idx);
		img_byte = img[idx*8 +: 8];
	endfunction

	// Table and segment share one memory address space
	assign rd_seg = {s_r.tbl[TBL_W-1:0], s_r.seg[7-TBL_W:0]};

	assign ipb.wr_en = store_cfg_i;
	assign ipb.wr_addr = cfg_addr_i;
	assign ipb.wr_mask = cfg_mask_i;

	fbg_ip_store u_store (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.ip(ipb)
	);

	fbg_seg_mem #(.AW(fbg_pkg::SEG_ADDR_W)) u_mem (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(pay_wr_i),
		.wr_seg_i(pay_wr_seg_i),
		.wr_data_i(pay_wr_data_i),
		.rd_seg_i(rd_seg),
		.rd_data_o(seg_data)
	);

	// Next state of receive, transmit and address selection
	always_comb begin
		s_nxt = s_r;
		s_nxt.rx_frame = 1'b0;
		// Receive: exactly twenty bytes form one frame
		if (rx_valid_i) begin
			s_nxt.rx_img[s_r.rx_cnt*8 +: 8] = rx_data_i;
			if (s_r.rx_cnt == 5'(fbg_pkg::IMG_BYTES - 1)) begin
				s_nxt.rx_cnt = '0;
				s_nxt.rx_frame = 1'b1;
			end else begin
				s_nxt.rx_cnt = s_r.rx_cnt + 5'd1;
			end
		end
		// Frame done: take inputs and the polling pair
		if (s_r.rx_frame) begin
			s_nxt.vin = s_r.rx_img[fbg_pkg::VIO_BITS-1:0];
			s_nxt.tbl = img_byte(s_r.rx_img, 5'(fbg_pkg::TBL_BYTE));
			s_nxt.seg = img_byte(s_r.rx_img, 5'(fbg_pkg::SEG_BYTE));
		end
		// Transmit state machine
		unique case (s_r.tx_st)
			fbg_pkg::FBG_IDLE: begin
				s_nxt.tx_valid = 1'b0;
				if (tx_start_i) begin
					s_nxt.tx_img = '0;
					// Image held at zero without exchange
					if (xchg_active_i) begin
						s_nxt.tx_img[fbg_pkg::VIO_BITS-1:0] = virt_out_i;
						s_nxt.tx_img[fbg_pkg::STAT_BYTE*8 +: 8] = {2'b00,
							1'b1, run_flag_i, diagnostic_flag_i,
							fault_flag_i, input_fault_flag_i,
							output_fault_flag_i};
						s_nxt.tx_img[fbg_pkg::PAY_FIRST*8 +: PAY_FIT] =
							seg_data[PAY_FIT-1:0];
					end
					s_nxt.tx_cnt = '0;
					s_nxt.tx_st = fbg_pkg::FBG_SHIFT;
				end
			end
			fbg_pkg::FBG_SHIFT: begin
				s_nxt.tx_valid = 1'b1;
				s_nxt.tx_data = img_byte(s_r.tx_img, s_r.tx_cnt);
				if (s_r.tx_cnt == 5'(fbg_pkg::IMG_BYTES - 1))
					s_nxt.tx_st = fbg_pkg::FBG_DONE;
				else
					s_nxt.tx_cnt = s_r.tx_cnt + 5'd1;
			end
			fbg_pkg::FBG_DONE: begin
				s_nxt.tx_valid = 1'b0;
				s_nxt.tx_st = fbg_pkg::FBG_IDLE;
			end
			default: begin
				s_nxt.tx_valid = 1'b0;
				s_nxt.tx_st = fbg_pkg::FBG_IDLE;
			end
		endcase
		// Address chosen at the first power-up pulse after reset; later pulses and switch moves ignored
		if (power_up_i && !s_r.ip_sampled) begin
			s_nxt.ip_sampled = 1'b1;
			if (dip_sw_i == fbg_pkg::SW_ZERO) begin
				s_nxt.from_store = 1'b1;
				s_nxt.ip_addr = ipb.rd_addr;
				s_nxt.ip_mask = ipb.rd_mask;
			end else begin
				s_nxt.from_store = 1'b0;
				// Switch byte used as plain binary
				s_nxt.ip_addr = {fbg_pkg::NET_PREFIX, dip_sw_i};
				s_nxt.ip_mask = fbg_pkg::NET_MASK;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= '0;
			s_r.tx_st <= fbg_pkg::FBG_IDLE;
			s_r.in_base <= fbg_pkg::IN_REG_BASE;
			s_r.out_base <= fbg_pkg::OUT_REG_BASE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state flops
	assign virt_in_o = s_r.vin;
	assign rx_frame_o = s_r.rx_frame;
	assign tx_valid_o = s_r.tx_valid;
	assign tx_data_o = s_r.tx_data;
	assign ip_addr_o = s_r.ip_addr;
	assign ip_mask_o = s_r.ip_mask;
	assign ip_from_store_o = s_r.from_store;
	// Area bases kept in flops so every output is registered
	assign in_reg_base_o = s_r.in_base;
	assign out_reg_base_o = s_r.out_base;
endmodule

// file: testbench/fbg_gateway_props.sv
// Concurrent checks on the gateway top-level ports
`timescale 1ns/100ps
module fbg_gateway_props (
	input wire logic ref_clk_i, // Clock
	input wire logic resetn_i, // Reset, active low
	input wire logic power_up_i, // Supply applied
	input wire logic [7:0] dip_sw_i, // Switches
	input wire logic xchg_active_i, // Exchange running
	input wire logic [4:0] flags_i, // Controller flags
	input wire logic tx_start_i, // Answer start
	input wire logic tx_valid_o, // Byte valid
	input wire logic [7:0] tx_data_o, // Byte
	input wire logic [31:0] ip_addr_o, // Address
	input wire logic [31:0] ip_mask_o, // Mask
	input wire logic ip_from_store_o, // Stored in use
	input wire logic [15:0] in_reg_base_o, // Input area
	input wire logic [15:0] out_reg_base_o // Output area
);
	logic seen_r;
	logic [4:0] cnt_r;
	logic x1_r;
	logic x2_r;
	logic xs_r;
	logic x_now;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	// Track the one address sample and the byte index of an answer
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seen_r <= 1'b0;
			cnt_r <= 5'h00;
			x1_r <= 1'b0;
			x2_r <= 1'b0;
			xs_r <= 1'b0;
		end else begin
			seen_r <= seen_r | power_up_i;
			cnt_r <= tx_valid_o ? cnt_r + 5'h01 : 5'h00;
			x1_r <= xchg_active_i;
			x2_r <= x1_r;
			if (tx_valid_o && cnt_r == 5'h00)
				xs_r <= x2_r;
		end
	end
	// Exchange flag as it stood when the answer was started
	assign x_now = (cnt_r == 5'h00) ? x2_r : xs_r;
	reg_base_a: assert property (in_reg_base_o == 16'h0000 &&
		out_reg_base_o == 16'h0400) else $error("area base wrong");
	tx_len_a: assert property ($rose(tx_valid_o) |-> ##19
		(tx_valid_o && cnt_r == 5'h13) ##1 !tx_valid_o) else $error("len");
	tx_lead_a: assert property ($rose(tx_valid_o) |->
		$past(tx_start_i, 2)) else $error("answer not after start");
	ip_sw_a: assert property (power_up_i && !seen_r && dip_sw_i != 8'h00
		|=> ip_addr_o == {24'hC0A800, $past(dip_sw_i)} &&
		ip_mask_o == 32'hFFFFFF00 && !ip_from_store_o) else $error("ip");
	ip_store_a: assert property (power_up_i && !seen_r &&
		dip_sw_i == 8'h00 |=> ip_from_store_o) else $error("no store");
	ip_hold_a: assert property (seen_r |=> $stable(ip_addr_o) &&
		$stable(ip_from_store_o)) else $error("address changed");
	stat_byte_a: assert property (tx_valid_o && cnt_r == 5'h10 &&
		x_now |-> tx_data_o == {3'b001, $past(flags_i, 18)})
		else $error("st");
	quiet_out_a: assert property (tx_valid_o && !x_now |->
		tx_data_o == 8'h00) else $error("output image not zero");
	cover property ($rose(tx_valid_o) && xchg_active_i);
	cover property ($rose(ip_from_store_o));
	cover property (power_up_i && dip_sw_i != 8'h00);
endmodule
bind fbg_gateway fbg_gateway_props u_props (.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i), .power_up_i(power_up_i), .dip_sw_i(dip_sw_i),
	.xchg_active_i(xchg_active_i), .flags_i({run_flag_i,
	diagnostic_flag_i, fault_flag_i, input_fault_flag_i,
	output_fault_flag_i}), .tx_start_i(tx_start_i),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .ip_addr_o(ip_addr_o),
	.ip_mask_o(ip_mask_o), .ip_from_store_o(ip_from_store_o),
	.in_reg_base_o(in_reg_base_o), .out_reg_base_o(out_reg_base_o));

// file: testbench/fbg_master_model.sv
// Fieldbus master model: sends input frames and polls answers
`timescale 1ns/100ps
module fbg_master_model (
	input wire logic ref_clk_i, // Clock
	input wire logic tx_valid_i, // Byte from device valid
	input wire logic [7:0] tx_data_i, // Byte from device
	output logic rx_valid_o, // Byte to device valid
	output logic [7:0] rx_data_o, // Byte to device
	output logic tx_start_o // Request an answer
);
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_start_o = 1'b0;
	end
	// Twenty bytes back to back, byte 0 first
	task automatic send_frame(input logic [159:0] f);
		for (int k = 0; k < 20; k++) begin
			@(posedge ref_clk_i);
			#1 rx_valid_o = 1'b1;
			rx_data_o = f[8*k+:8];
		end
		@(posedge ref_clk_i);
		#1 rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o; // Released line shows no stale byte
	endtask
	// Sample at the falling edge, clear of the design's updates
	task automatic poll(output logic [159:0] f);
		int k;
		k = 0;
		f = 'x; // Missing bytes stay unknown and fail the compare
		@(posedge ref_clk_i);
		#1 tx_start_o = 1'b1;
		@(posedge ref_clk_i);
		#1 tx_start_o = 1'b0;
		for (int w = 0; w < 40 && k < 20; w++) begin
			@(negedge ref_clk_i);
			if (tx_valid_i === 1'b1) begin
				f[8*k+:8] = tx_data_i;
				k++;
			end
		end
		// Back in step: callers move inputs just after a rising edge
		@(posedge ref_clk_i);
		#1;
	endtask
endmodule

// file: testbench/fbg_gateway_test.sv
// Self-checking bench for the process image gateway
`timescale 1ns/100ps
module fbg_gateway_test;
	logic ref_clk_i, resetn_i, pwr, xchg, pay_wr, store;
	logic rx_valid, tx_start, rx_frame, tx_valid, from_store;
	logic [4:0] fl;
	logic [7:0] dip, rx_data, tx_data;
	logic [127:0] vo, vi, virt_in;
	logic [159:0] f;
	logic [31:0] ip_addr, ip_mask, cfg_addr, cfg_mask;
	logic [15:0] in_base, out_base;
	int n_mismatch = 0;
	int num_checks = 0;
	fbg_gateway dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.power_up_i(pwr), .dip_sw_i(dip), .xchg_active_i(xchg),
		.virt_out_i(vo), .output_fault_flag_i(fl[0]),
		.input_fault_flag_i(fl[1]), .fault_flag_i(fl[2]),
		.diagnostic_flag_i(fl[3]), .run_flag_i(fl[4]), .pay_wr_i(pay_wr),
		.pay_wr_seg_i(8'h35), .pay_wr_data_i({96'h0, 24'hC3B2A1}),
		.rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_start_i(tx_start),
		.store_cfg_i(store), .cfg_addr_i(cfg_addr), .cfg_mask_i(cfg_mask),
		.virt_in_o(virt_in), .rx_frame_o(rx_frame), .tx_valid_o(tx_valid),
		.tx_data_o(tx_data), .ip_addr_o(ip_addr), .ip_mask_o(ip_mask),
		.ip_from_store_o(from_store), .in_reg_base_o(in_base),
		.out_reg_base_o(out_base));
	fbg_master_model fm (.ref_clk_i(ref_clk_i), .tx_valid_i(tx_valid),
		.tx_data_i(tx_data), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.tx_start_o(tx_start));
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic clk(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One supply-on pulse, then let the address settle
	task automatic power_on();
		pwr = 1'b1;
		clk(1);
		pwr = 1'b0;
		clk(2);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog: the sequence needs well under 1000 cycles
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{resetn_i, pwr, xchg, pay_wr, store, fl, vo} = '0;
		{dip, cfg_addr, cfg_mask} = '0;
		vi = {1'b1, 114'h0, 1'b1, 12'h000}; // Inputs twelve and 127
		clk(4);
		resetn_i = 1'b1;
		dip = 8'h14;
		power_on();
		chk({ip_addr, ip_mask, from_store}, {64'hC0A80014FFFFFF00, 1'b0});
		dip = 8'h00;
		power_on();
		chk(ip_addr, 32'hC0A80014);
		chk({in_base, out_base}, 32'h00000400);
		// Second power cycle: stored settings win with switches at zero
		resetn_i = 1'b0;
		clk(4);
		resetn_i = 1'b1;
		{store, cfg_addr, cfg_mask} = {1'b1, 64'hAC10D88BFFFF0000};
		clk(1);
		store = 1'b0;
		power_on();
		chk({ip_addr, ip_mask, from_store}, {64'hAC10D88BFFFF0000, 1'b1});
		fm.poll(f);
		chk(f, 160'h0);
		xchg = 1'b1;
		pay_wr = 1'b1;
		clk(1);
		pay_wr = 1'b0;
		fm.send_frame({8'hEE, 8'h05, 8'h03, 8'hEE, vi});
		chk(rx_frame, 1'b1);
		clk(1);
		chk(rx_frame, 1'b0);
		clk(2);
		chk(virt_in, vi);
		// Each flag set once across two answers
		for (int i = 0; i < 2; i++) begin
			fl = i ? 5'h0A : 5'h15;
			vo = i ? {1'b1, 127'h0} : 128'h20;
			clk(1);
			fm.poll(f);
			chk(f, {24'hC3B2A1, 3'b001, fl, vo});
		end
		tally_and_finish();
	end
endmodule
